// ==== shared/fpmc_map.svh ====
// constants of the flash programming mode control
`ifndef FPMC_MAP_SVH
`define FPMC_MAP_SVH
`define FPMC_ADDR_W 12
`define FPMC_ROW_BYTES 32
`define FPMC_ROW_IDX_W 5
`define FPMC_RAM_ADDR_W 8
`define FPMC_ENTRY_EDGES 3'h4
`define FPMC_ENTRY_CNT_W 3
`define FPMC_BIT_CNT_W 3
`define FPMC_BIT_LAST 3'h7
`define FPMC_ROW_LAST 5'h1F
`define FPMC_ZERO_MASK 32'h0000_0000
`define FPMC_BYTE_ZERO 8'h00
`endif

// ==== shared/fpmc_pkg.sv ====
// types of the flash programming mode control
`include "fpmc_map.svh"
package fpmc_pkg;
    typedef enum logic [1:0] {area_sector0, area_sector1, area_option_row, area_eeprom} fpmc_area_t;
    typedef enum logic [1:0] {op_latch, op_program, op_erase, op_none} fpmc_op_t;
    typedef struct packed {
        logic valid;
        fpmc_op_t op;
        fpmc_area_t area;
        logic [`FPMC_ADDR_W-1:0] addr;
        logic [7:0] data;
        logic from_sector0;
    } fpmc_req_t;
    typedef struct packed {
        logic done;
        logic denied;
    } fpmc_resp_t;
    typedef struct packed {
        logic wr;
        logic erase;
        fpmc_area_t area;
        logic [`FPMC_ADDR_W-1:0] addr;
        logic [7:0] data;
    } fpmc_flash_cmd_t;
    typedef struct packed {
        logic we;
        logic [`FPMC_RAM_ADDR_W-1:0] addr;
        logic [7:0] data;
    } fpmc_ram_wr_t;
    typedef struct packed {
        logic drive;
        logic level;
    } fpmc_sclk_cfg_t;
endpackage

// ==== verilog/fpmc_top.sv ====
// flash programming mode control: session entry, driver download, guarded sequencer
`timescale 1ns/100ps
`include "fpmc_map.svh"
module fpmc_top (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic reset_pin_n_i,
    input wire logic tool_socket_i,
    input wire logic prog_serial_clock_i,
    input wire logic prog_serial_data_i,
    input wire fpmc_pkg::fpmc_sclk_cfg_t sclk_cfg_i,
    input wire fpmc_pkg::fpmc_req_t req_i,
    output logic prog_serial_clock_o,
    output logic prog_serial_clock_oe_o,
    output logic prog_serial_clock_pullup_o,
    output logic in_circuit_comm_mode_o,
    output logic sys_vector_o,
    output logic driver_exec_o,
    output logic busy_o,
    output fpmc_pkg::fpmc_resp_t resp_o,
    output fpmc_pkg::fpmc_flash_cmd_t flash_cmd_o,
    output fpmc_pkg::fpmc_ram_wr_t ram_wr_o
);
    import fpmc_pkg::*;

    typedef enum {ses_off, ses_entry, ses_len, ses_load, ses_exec} fpmc_ses_t;
    typedef enum {seq_idle, seq_write} fpmc_seq_t;

    function automatic logic area_allowed(input fpmc_area_t area, input logic tool,
                                          input logic from_s0);
        if (tool) begin
            area_allowed = 1'b1;
        end else begin
            area_allowed = from_s0 && (area == area_sector1 || area == area_eeprom);
        end
    endfunction

    // pin synchronisers
    logic [1:0] rst_pin_s;
    logic [1:0] sock_s;
    logic [2:0] sclk_s;
    logic [1:0] sdata_s;
    always_ff @(posedge clock_i) begin
        rst_pin_s <= {rst_pin_s[0], reset_pin_n_i};
        sock_s <= {sock_s[0], tool_socket_i};
        sclk_s <= {sclk_s[1:0], prog_serial_clock_i};
        sdata_s <= {sdata_s[0], prog_serial_data_i};
    end
    wire logic rst_pin_lo = !rst_pin_s[1];
    wire logic sclk_rise = sclk_s[1] && !sclk_s[2];
    wire logic sdata = sdata_s[1];
    wire logic tool_mode = in_circuit_comm_mode_o || sock_s[1];

    // serial clock pin ownership
    always_ff @(posedge clock_i) begin
        if (!resetn_i || rst_pin_lo) begin
            prog_serial_clock_oe_o <= 1'b0;
            prog_serial_clock_o <= 1'b1;
            prog_serial_clock_pullup_o <= 1'b1;
        end else begin
            prog_serial_clock_oe_o <= sclk_cfg_i.drive && !in_circuit_comm_mode_o;
            prog_serial_clock_o <= sclk_cfg_i.level;
            prog_serial_clock_pullup_o <= !sclk_cfg_i.drive || in_circuit_comm_mode_o;
        end
    end

    // session: entry, download, execution
    fpmc_ses_t ses;
    logic [`FPMC_ENTRY_CNT_W-1:0] entry_cnt;
    logic [`FPMC_BIT_CNT_W-1:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] load_len;
    logic [`FPMC_RAM_ADDR_W-1:0] load_addr;
    wire logic [7:0] next_shift = {shift[6:0], sdata};
    wire logic byte_done = sclk_rise && bit_cnt == `FPMC_BIT_LAST;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            ses <= ses_off;
            entry_cnt <= '0;
            bit_cnt <= '0;
            shift <= `FPMC_BYTE_ZERO;
            load_len <= `FPMC_BYTE_ZERO;
            load_addr <= '0;
            in_circuit_comm_mode_o <= 1'b0;
            sys_vector_o <= 1'b0;
            driver_exec_o <= 1'b0;
            ram_wr_o <= '0;
        end else begin
            driver_exec_o <= 1'b0;
            sys_vector_o <= 1'b0;
            ram_wr_o.we <= 1'b0;
            if (sclk_rise) begin
                shift <= next_shift;
                bit_cnt <= bit_cnt + 1'b1;
            end
            case (ses)
                ses_off: begin
                    entry_cnt <= '0;
                    if (rst_pin_lo) begin
                        ses <= ses_entry;
                    end
                end
                ses_entry: begin
                    bit_cnt <= '0;
                    if (sclk_rise && !sdata && entry_cnt != `FPMC_ENTRY_EDGES) begin
                        entry_cnt <= entry_cnt + 1'b1;
                    end
                    if (!rst_pin_lo) begin
                        if (entry_cnt == `FPMC_ENTRY_EDGES) begin
                            in_circuit_comm_mode_o <= 1'b1;
                            sys_vector_o <= 1'b1;
                            ses <= ses_len;
                        end else begin
                            ses <= ses_off;
                        end
                    end
                end
                ses_len: begin
                    if (byte_done) begin
                        load_len <= next_shift;
                        load_addr <= '0;
                        ses <= (next_shift == `FPMC_BYTE_ZERO) ? ses_exec : ses_load;
                        driver_exec_o <= next_shift == `FPMC_BYTE_ZERO;
                    end
                end
                ses_load: begin
                    if (byte_done) begin
                        ram_wr_o.we <= 1'b1;
                        ram_wr_o.addr <= load_addr;
                        ram_wr_o.data <= next_shift;
                        load_addr <= load_addr + 1'b1;
                        if ({1'b0, load_addr} + 9'h001 == {1'b0, load_len}) begin
                            ses <= ses_exec;
                            driver_exec_o <= 1'b1;
                        end
                    end
                end
                ses_exec: begin
                    bit_cnt <= '0;
                end
                default: begin
                    ses <= ses_off;
                end
            endcase
            if (rst_pin_lo && ses != ses_off && ses != ses_entry) begin
                ses <= ses_entry;
                entry_cnt <= '0;
                in_circuit_comm_mode_o <= 1'b0;
            end
        end
    end

    // row latches and program sequencer
    logic [7:0] row_data [`FPMC_ROW_BYTES];
    logic [`FPMC_ROW_BYTES-1:0] row_mask;
    logic [`FPMC_ADDR_W-1:`FPMC_ROW_IDX_W] row_base;
    fpmc_area_t row_area;
    fpmc_seq_t seq;
    logic [`FPMC_ROW_IDX_W-1:0] wr_idx;
    wire logic req_take = req_i.valid && seq == seq_idle;
    wire logic req_ok = area_allowed(req_i.area, tool_mode, req_i.from_sector0);
    wire logic [`FPMC_ROW_IDX_W-1:0] req_idx = req_i.addr[`FPMC_ROW_IDX_W-1:0];

    always_ff @(posedge clock_i) begin
        if (req_take && req_ok && req_i.op == op_latch) begin
            row_data[req_idx] <= req_i.data;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            seq <= seq_idle;
            row_mask <= `FPMC_ZERO_MASK;
            row_base <= '0;
            row_area <= area_sector0;
            wr_idx <= '0;
            busy_o <= 1'b0;
            resp_o <= '0;
            flash_cmd_o <= '0;
        end else begin
            resp_o <= '0;
            flash_cmd_o.wr <= 1'b0;
            flash_cmd_o.erase <= 1'b0;
            case (seq)
                seq_idle: begin
                    if (req_take) begin
                        if (!req_ok || req_i.op == op_none) begin
                            resp_o <= '{done: 1'b1, denied: 1'b1};
                        end else if (req_i.op == op_latch) begin
                            row_mask[req_idx] <= 1'b1;
                            row_base <= req_i.addr[`FPMC_ADDR_W-1:`FPMC_ROW_IDX_W];
                            row_area <= req_i.area;
                            resp_o <= '{done: 1'b1, denied: 1'b0};
                        end else if (req_i.op == op_erase) begin
                            flash_cmd_o <= '{wr: 1'b0, erase: 1'b1, area: req_i.area,
                                             addr: req_i.addr, data: `FPMC_BYTE_ZERO};
                            resp_o <= '{done: 1'b1, denied: 1'b0};
                        end else if (row_mask == `FPMC_ZERO_MASK) begin
                            flash_cmd_o <= '{wr: 1'b1, erase: 1'b0, area: req_i.area,
                                             addr: req_i.addr, data: req_i.data};
                            resp_o <= '{done: 1'b1, denied: 1'b0};
                        end else if (!area_allowed(row_area, tool_mode, req_i.from_sector0)) begin
                            resp_o <= '{done: 1'b1, denied: 1'b1};
                        end else begin
                            seq <= seq_write;
                            wr_idx <= '0;
                            busy_o <= 1'b1;
                        end
                    end
                end
                seq_write: begin
                    if (row_mask[wr_idx]) begin
                        flash_cmd_o <= '{wr: 1'b1, erase: 1'b0, area: row_area,
                                         addr: {row_base, wr_idx},
                                         data: row_data[wr_idx]};
                    end
                    wr_idx <= wr_idx + 1'b1;
                    if (wr_idx == `FPMC_ROW_LAST) begin
                        row_mask <= `FPMC_ZERO_MASK;
                        seq <= seq_idle;
                        busy_o <= 1'b0;
                        resp_o <= '{done: 1'b1, denied: 1'b0};
                    end
                end
                default: begin
                    seq <= seq_idle;
                end
            endcase
        end
    end
endmodule

// ==== verif/fpmc_top_asserts.sv ====
// assertion checker of the flash programming mode control
`timescale 1ns/100ps
module fpmc_top_asserts (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic reset_pin_n_i,
    input wire logic tool_socket_i,
    input wire fpmc_pkg::fpmc_req_t req_i,
    input wire logic prog_serial_clock_oe_o,
    input wire logic prog_serial_clock_pullup_o,
    input wire logic in_circuit_comm_mode_o,
    input wire logic sys_vector_o,
    input wire logic driver_exec_o,
    input wire logic busy_o,
    input wire fpmc_pkg::fpmc_resp_t resp_o,
    input wire fpmc_pkg::fpmc_flash_cmd_t flash_cmd_o,
    input wire fpmc_pkg::fpmc_ram_wr_t ram_wr_o
);
    import fpmc_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    logic [3:0] sock_hist;
    always_ff @(posedge clock_i) begin
        sock_hist <= {sock_hist[2:0], tool_socket_i};
    end
    wire app_take = req_i.valid && !busy_o && !in_circuit_comm_mode_o && sock_hist == 4'h0;
    reset_pins_a:
    assert property (@(posedge clock_i) disable iff (1'b0) !resetn_i |=>
        !prog_serial_clock_oe_o && prog_serial_clock_pullup_o) else $error("pin kept by reset");
    pin_low_a:
    assert property (!reset_pin_n_i [*4] |-> !in_circuit_comm_mode_o && prog_serial_clock_pullup_o)
        else $error("session kept in reset");
    vector_fetch_a:
    assert property ($rose(in_circuit_comm_mode_o) |-> sys_vector_o ##1 !sys_vector_o)
        else $error("no vector fetch");
    session_order_a:
    assert property (ram_wr_o.we || driver_exec_o |-> in_circuit_comm_mode_o)
        else $error("download outside session");
    tool_open_a:
    assert property (req_i.valid && !busy_o && in_circuit_comm_mode_o && req_i.op == op_erase |=>
        flash_cmd_o.erase && !resp_o.denied && flash_cmd_o.area == $past(req_i.area))
        else $error("tool erase refused");
    sector0_lock_a:
    assert property (app_take && req_i.area == area_sector0 |=> resp_o.denied && !flash_cmd_o.erase)
        else $error("sector0 open");
    option_lock_a:
    assert property (app_take && req_i.area == area_option_row |=> resp_o.denied)
        else $error("option row open");
    row_time_a:
    assert property ($rose(busy_o) |=> ##31 (!busy_o && resp_o.done)) else $error("row time");
    cover property ($rose(in_circuit_comm_mode_o));
    cover property (driver_exec_o);
    cover property ($rose(busy_o));
endmodule
bind fpmc_top fpmc_top_asserts i_chk (.clock_i(clock_i), .resetn_i(resetn_i),
    .reset_pin_n_i(reset_pin_n_i), .tool_socket_i(tool_socket_i), .req_i(req_i),
    .prog_serial_clock_oe_o(prog_serial_clock_oe_o), .busy_o(busy_o),
    .prog_serial_clock_pullup_o(prog_serial_clock_pullup_o), .resp_o(resp_o),
    .in_circuit_comm_mode_o(in_circuit_comm_mode_o), .sys_vector_o(sys_vector_o),
    .driver_exec_o(driver_exec_o), .flash_cmd_o(flash_cmd_o), .ram_wr_o(ram_wr_o));

// ==== verif/fpmc_tool.sv ====
// programming tool model on the serial link and reset pin
`timescale 1ns/100ps
module fpmc_tool (
    output logic reset_pin_n_o,
    output logic sclk_o,
    output logic sdata_o
);
    initial begin
        reset_pin_n_o = 1'b1;
        sclk_o = 1'b1;
        sdata_o = 1'b1;
    end
    task automatic pulse(input logic b);
        sclk_o <= 1'b0;
        #200 sdata_o <= b;
        #200 sclk_o <= 1'b1;
        #400;
    endtask
    task automatic enter(input int rises);
        reset_pin_n_o <= 1'b0;
        #800;
        repeat (rises) pulse(1'b0);
        reset_pin_n_o <= 1'b1;
        sdata_o <= ~sdata_o;
        #800;
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) pulse(b[i]);
        sdata_o <= ~sdata_o;
    endtask
    task automatic end_session();
        reset_pin_n_o <= 1'b0;
        #800;
        reset_pin_n_o <= 1'b1;
    endtask
endmodule

// ==== verif/tb.sv ====
// self-checking testbench of the flash programming mode control
`timescale 1ns/100ps
module tb;
    import fpmc_pkg::*;
    logic clock_i, resetn_i, sock, s_clk, oe, pu, comm, vec, exec, busy, rpin, t_clk, t_dat, d;
    fpmc_sclk_cfg_t cfg;
    fpmc_req_t req;
    fpmc_resp_t resp;
    fpmc_flash_cmd_t fc;
    fpmc_ram_wr_t rw;
    logic [7:0] ram [0:3];
    logic [11:0] wr_last;
    fpmc_area_t er_area;
    fpmc_area_t wr_area;
    int n_mismatch = 0, num_checks = 0, n_vec = 0, n_exec = 0, n_wr = 0;
    wire sclk_w = oe ? s_clk : t_clk;
    fpmc_tool i_tool (.reset_pin_n_o(rpin), .sclk_o(t_clk), .sdata_o(t_dat));
    fpmc_top i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .reset_pin_n_i(rpin),
        .tool_socket_i(sock), .prog_serial_clock_i(sclk_w), .prog_serial_data_i(t_dat),
        .sclk_cfg_i(cfg), .req_i(req), .prog_serial_clock_o(s_clk), .prog_serial_clock_oe_o(oe),
        .prog_serial_clock_pullup_o(pu), .in_circuit_comm_mode_o(comm), .sys_vector_o(vec),
        .driver_exec_o(exec), .busy_o(busy), .resp_o(resp), .flash_cmd_o(fc), .ram_wr_o(rw));
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i; // stands for the device's clock input
    end
    always @(negedge clock_i) begin
        if (vec === 1'b1) n_vec++;
        if (exec === 1'b1) n_exec++;
        if (rw.we === 1'b1) ram[rw.addr[1:0]] = rw.data;
        if (fc.wr === 1'b1) begin
            n_wr++;
            wr_last = fc.addr;
            wr_area = fc.area;
        end
        if (fc.erase === 1'b1) er_area = fc.area;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic issue(input fpmc_op_t op, input fpmc_area_t ar, input logic [11:0] ad,
        input logic s0);
        int k;
        @(posedge clock_i);
        req <= '{valid: 1'b1, op: op, area: ar, addr: ad, data: 8'h5A, from_sector0: s0};
        @(posedge clock_i);
        req.valid <= 1'b0;
        for (k = 0; k < 40 && resp.done !== 1'b1; k++) @(negedge clock_i);
        if (k == 40) begin
            n_mismatch++;
            close_out();
        end
        d = resp.denied;
        @(posedge clock_i);
    endtask
    task automatic test_reset();
        resetn_i <= 1'b1;
        cfg <= 2'h2;
        repeat (4) @(posedge clock_i);
        chk("oe driven", 16'h1, oe);
        chk("pullup off", 16'h0, pu);
        chk("pin level", 16'h0, s_clk);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk("oe", 16'h0, oe);
        chk("pullup", 16'h1, pu);
        chk("pin idle", 16'h1, s_clk);
        cfg <= 2'h0;
        resetn_i <= 1'b1;
        $display("test reset done");
    endtask
    task automatic test_session();
        i_tool.enter(3);
        chk("short entry", 16'h0, {comm, 7'h0, n_vec[7:0]});
        i_tool.enter(4);
        chk("entry", 16'h0101, {7'h0, comm, n_vec[7:0]});
        i_tool.send_byte(8'h02);
        i_tool.send_byte(8'hA5);
        i_tool.send_byte(8'h3C);
        repeat (4) @(posedge clock_i);
        chk("download", 16'hA53C, {ram[0], ram[1]});
        chk("exec", 16'h1, n_exec[15:0]);
        for (int a = 0; a < 4; a++) begin
            issue(op_erase, fpmc_area_t'(a), 12'h040, 1'b0);
            chk("tool erase", a[15:0], {d, 13'h0, er_area});
        end
        $display("test session done");
    endtask
    task automatic test_application();
        i_tool.end_session();
        for (int a = 0; a < 4; a++) begin
            issue(op_erase, fpmc_area_t'(a), 12'h040, 1'b1);
            chk("app erase", {15'h0, a == 0 || a == 2}, d);
        end
        issue(op_erase, area_sector1, 12'h040, 1'b0);
        chk("driver outside sector0", 16'h1, d);
        issue(op_latch, area_sector1, 12'h103, 1'b1);
        issue(op_latch, area_sector1, 12'h107, 1'b1);
        n_wr = 0;
        issue(op_program, area_sector1, 12'h100, 1'b1);
        chk("row writes", 16'h2107, {n_wr[3:0], wr_last});
        chk("row area", 16'h1, {14'h0, wr_area});
        issue(op_program, area_eeprom, 12'h020, 1'b1);
        chk("byte write", 16'h3020, {n_wr[3:0], wr_last});
        $display("test application done");
    endtask
    task automatic test_socket();
        i_tool.enter(4);
        i_tool.send_byte(8'h00);
        repeat (4) @(posedge clock_i);
        chk("empty driver", 16'h0202, {n_vec[7:0], n_exec[7:0]});
        i_tool.end_session();
        sock <= 1'b1;
        repeat (4) @(posedge clock_i);
        issue(op_erase, area_sector0, 12'h000, 1'b0);
        chk("socket erase", 16'h0, {d, 13'h0, er_area});
        $display("test socket done");
    endtask
    initial begin
        resetn_i = 1'b0;
        sock = 1'b0;
        cfg = 2'h0;
        req = '0;
        repeat (16) @(posedge clock_i);
        test_reset();
        test_session();
        test_application();
        test_socket();
        close_out();
    end
endmodule
